/* hw/wdt_pkg.sv */
// Constants and state type for the watchdog timer with feed shadow.
// Behaviour
// (R1) ROM part reads mode from factory bit; the code does so only with the pin high.
// (R2) Factory watchdog mode ignores run bit.
// (R3) Divide by 12, 13-stage prescaler, taps 6-13.
// (R4) Main counter decrements once per tap tick.
// (R5) Tick at zero underflows and autoloads.
// (R6) Counter and autoload value are 8 bits.
// (R7) Autoload clears the prescaler.
// (R8) Timeout is 768 x 2^tap x (load+1).
// (R9) Software feeds within each design timeout.
// (R10) ROM part with pin high: mode, tap read-only; the code fixes the timer tap only in factory watchdog mode.
// (R11) Run read-only in factory watchdog mode only.
// (R12) Mode and tap reach shadow only on feed.
// (R13) Reset gives watchdog mode, longest tap, load zero.
// (R14) Timer never raises an interrupt.
// (R15) Control writes take effect only through feed.
// (R16) Control bit layout and reset values fixed.
// (R17) Cleared enables block detector resets.
// (R18) Internal reset held 24 periods after detectors.
// (R19) Internal reset gates address-latch strobe only.
// (R20) Feed is A5 then 5A; bad second underflows.
// (R21) Watchdog underflow autoloads, flags, resets system.
// (R22) Timer underflow autoloads and flags only.
// (R23) External reset restores defaults and autoloads.
// (R24) Stopped timer holds and never underflows; the code still underflows on a bad second key.
// (R25) Software and reset clear timeout flag.
package wdt_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'hc0;
    localparam logic [7:0] OFS_AUTOLOAD = 8'hc4;
    localparam logic [7:0] OFS_FEED1 = 8'hc8;
    localparam logic [7:0] OFS_FEED2 = 8'hcc;
    localparam logic [7:0] OFS_STATUS = 8'hd0;
    localparam int BIT_TAP = 5;
    localparam int BIT_LOWVOLT_RESET_ENABLE = 4;
    localparam int BIT_OSCFAIL_RESET_ENABLE = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_TOF = 1;
    localparam int BIT_MODE = 0;
    localparam logic [2:0] RST_TAP = 3'h7;
    localparam logic RST_LOWVOLT_RESET_ENABLE = 1'b1;
    localparam logic RST_OSCFAIL_RESET_ENABLE = 1'b1;
    localparam logic RST_RUN = 1'b1;
    localparam logic RST_TOF = 1'b0;
    localparam logic RST_MODE = 1'b1;
    localparam logic [7:0] RST_AUTOLOAD = 8'h00;
    localparam logic [7:0] FEED_KEY1 = 8'ha5;
    localparam logic [7:0] FEED_KEY2 = 8'h5a;
    localparam int DIV_OSC = 12;
    localparam logic [3:0] DIV_LAST = 4'(DIV_OSC - 1);
    localparam logic [3:0] TAP_BASE = 4'h6;
    localparam logic [12:0] PRE_ONES = 13'h1fff;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_PERIOD_NS = 5;
    localparam int RST_HOLD_OSC = 24;
    localparam logic [4:0] RST_HOLD_CYC = 5'(RST_HOLD_OSC * OSC_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic armed;
        logic pend_valid;
        logic [7:0] pend_ctl;
        logic [2:0] tap;
        logic lowvolt_reset_enable;
        logic oscfail_reset_enable;
        logic run;
        logic tof;
        logic mode;
        logic [7:0] autoload;
        logic sh_mode;
        logic [2:0] sh_tap;
        logic [3:0] div;
        logic [12:0] pre;
        logic [7:0] cnt;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [4:0] hold;
        logic sysrst;
        logic under;
    } wdt_state_t;
endpackage

/* hw/wdt_top.sv */
`timescale 1ns/1ps
// Watchdog and interval timer with feed shadow, internal reset timer and AXI4-Lite slave.
module wdt_top
    import wdt_pkg::*;
#(
    parameter bit ROM_PART = 1'b0,
    parameter bit FACTORY_MODE = 1'b1,
    parameter logic [2:0] FACTORY_TAP = 3'h7,
    parameter logic [7:0] FACTORY_LOAD = 8'h00
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_access_pin,
    input wire logic poweron_detect,
    input wire logic lowvolt_detect,
    input wire logic oscfail_detect,
    output logic sys_reset_out,
    output logic ale_enable,
    output logic wd_underflow
);

    wdt_state_t s;
    wdt_state_t n;

    logic mask_on;
    logic mask_wd;
    logic eff_mode;
    logic [2:0] eff_tap;
    logic [7:0] eff_load;
    logic eff_run;
    logic [7:0] ctl_rd;
    logic wr_go;
    logic wr_ok;
    logic key2_wr;
    logic feed_ok;
    logic feed_bad;
    logic div_tick;
    logic [12:0] tap_mask;
    logic tap_tick;
    logic under_any;
    logic det_active;

    // Factory values replace the shadow only in the ROM part with the pin high.
    assign mask_on = ROM_PART && s.sync2[3]; // see (R1)
    assign mask_wd = mask_on && FACTORY_MODE; // see (R2)
    assign eff_mode = mask_on ? FACTORY_MODE : s.sh_mode; // see (R1)
    assign eff_tap = mask_wd ? FACTORY_TAP : s.sh_tap;
    assign eff_load = mask_wd ? FACTORY_LOAD : s.autoload;
    assign eff_run = mask_wd ? 1'b1 : s.run; // see (R2)

    // Control readback shows factory mode and tap whenever the ROM part has the pin high.
    assign ctl_rd = {mask_on ? FACTORY_TAP : s.tap, s.lowvolt_reset_enable, s.oscfail_reset_enable, s.run, s.tof,
                     mask_on ? FACTORY_MODE : s.mode}; // see (R10) see (R16)

    // A write executes once both address and data are held.
    assign wr_go = s.aw_full && s.w_full && !s.bvalid;
    assign wr_ok = wr_go && s.w_en;
    assign key2_wr = wr_ok && s.aw_addr == OFS_FEED2 && s.armed;
    assign feed_ok = key2_wr && s.w_data == FEED_KEY2; // see (R20)
    assign feed_bad = key2_wr && s.w_data != FEED_KEY2; // see (R20)

    // Prescaler tap decode: tap k ticks every 2^(6+k) divided clocks.
    assign div_tick = eff_run && s.div == DIV_LAST; // see (R3) see (R24)
    assign tap_mask = ~(PRE_ONES << (TAP_BASE + {1'b0, eff_tap})); // see (R3) see (R8)
    assign tap_tick = div_tick && (s.pre & tap_mask) == tap_mask;
    assign under_any = feed_bad || (tap_tick && s.cnt == 8'h00 && !feed_ok); // see (R5)

    // Power-on always resets; the other detectors only when enabled.
    assign det_active = s.sync2[2] || (s.sync2[1] && s.lowvolt_reset_enable) || (s.sync2[0] && s.oscfail_reset_enable); // see (R17)

    // Bus handshakes and block outputs.
    assign s_axi_awready = !s.aw_full;
    assign s_axi_wready = !s.w_full;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign sys_reset_out = s.sysrst; // see (R19)
    assign ale_enable = !s.sysrst; // see (R19)
    assign wd_underflow = s.under;
    // The block has no interrupt output in any mode.  see (R14)

    // Next-state logic for the bus slave, control register and timer.
    always_comb
    begin
        n = s;
        n.under = 1'b0;
        n.sync1 = {external_access_pin, poweron_detect, lowvolt_detect, oscfail_detect};
        n.sync2 = s.sync1;

        // Write address and data channels are taken independently.
        if (s_axi_awvalid && !s.aw_full)
        begin
            n.aw_full = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_full)
        begin
            n.w_full = 1'b1;
            n.w_data = s_axi_wdata[7:0];
            n.w_en = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end

        // Register write decode; any write except a good first key disarms.
        if (wr_go)
        begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            n.armed = 1'b0;
            case (s.aw_addr)
                OFS_CONTROL:
                begin
                    if (s.w_en)
                    begin
                        n.pend_ctl = s.w_data; // see (R15)
                        n.pend_valid = 1'b1;
                    end
                end
                OFS_AUTOLOAD:
                begin
                    if (s.w_en)
                    begin
                        n.autoload = s.w_data; // see (R6)
                    end
                end
                OFS_FEED1:
                begin
                    n.armed = s.w_en && s.w_data == FEED_KEY1; // see (R20)
                end
                OFS_FEED2:
                begin
                    n.armed = 1'b0;
                end
                OFS_STATUS:
                begin
                    if (s.w_en && s.w_data[0])
                    begin
                        n.tof = 1'b0; // see (R25)
                    end
                end
                default:
                begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Read channel returns registered data one cycle after the address.
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CONTROL: n.rdata = {24'h00_0000, ctl_rd};
                OFS_AUTOLOAD: n.rdata = {24'h00_0000, s.autoload};
                OFS_FEED1: n.rdata = 32'h0000_0000;
                OFS_FEED2: n.rdata = 32'h0000_0000;
                OFS_STATUS: n.rdata = {19'h0_0000, s.armed, eff_tap, eff_mode, s.cnt};
                default:
                begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end

        // A good feed commits the pending control value, then the shadow.
        if (feed_ok)
        begin
            if (s.pend_valid)
            begin
                n.tap = s.pend_ctl[BIT_TAP +: 3]; // see (R15)
                n.lowvolt_reset_enable = s.pend_ctl[BIT_LOWVOLT_RESET_ENABLE];
                n.oscfail_reset_enable = s.pend_ctl[BIT_OSCFAIL_RESET_ENABLE];
                n.mode = s.pend_ctl[BIT_MODE];
                if (!mask_wd)
                begin
                    n.run = s.pend_ctl[BIT_RUN]; // see (R11)
                end
                n.pend_valid = 1'b0;
            end
            n.sh_mode = n.mode; // see (R12)
            n.sh_tap = n.tap; // see (R12)
            n.cnt = eff_load;
            n.pre = 13'h0000; // see (R7)
            n.div = 4'h0;
        end
        else if (under_any)
        begin
            // Underflow autoloads and flags; only watchdog mode resets.
            n.under = 1'b1;
            n.cnt = eff_load; // see (R5) see (R21) see (R22)
            n.pre = 13'h0000; // see (R7)
            n.div = 4'h0;
        end
        else if (div_tick)
        begin
            n.div = 4'h0; // see (R3)
            n.pre = s.pre + 13'h0001;
            if (tap_tick)
            begin
                n.cnt = s.cnt - 8'h01; // see (R4)
            end
        end
        else if (eff_run)
        begin
            n.div = s.div + 4'h1;
        end

        // Hardware set of the flag wins over a software clear.
        if (under_any && !feed_ok)
        begin
            n.tof = 1'b1; // see (R21) see (R22)
        end

        // Self-timed internal reset after detectors or a watchdog underflow.
        if (det_active || (under_any && !feed_ok && eff_mode))
        begin
            n.hold = RST_HOLD_CYC; // see (R18) see (R21)
        end
        else if (s.hold != 5'h00)
        begin
            n.hold = s.hold - 5'h01;
        end
        n.sysrst = det_active || n.hold != 5'h00; // see (R18)
    end

    // State register; external reset restores defaults and autoloads.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0; // see (R23) see (R25)
            s.tap <= RST_TAP; // see (R13) see (R16)
            s.lowvolt_reset_enable <= RST_LOWVOLT_RESET_ENABLE;
            s.oscfail_reset_enable <= RST_OSCFAIL_RESET_ENABLE;
            s.run <= RST_RUN;
            s.tof <= RST_TOF;
            s.mode <= RST_MODE;
            s.autoload <= RST_AUTOLOAD;
            s.sh_mode <= RST_MODE;
            s.sh_tap <= RST_TAP;
            s.cnt <= RST_AUTOLOAD;
        end
        else
        begin
            s <= n;
        end
    end

    // Checks on the timer, feed logic and internal reset.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_under_flag: assert property (under_any && !feed_ok |=> s.tof) // see (R22)
        else $error("Underflow did not set the timeout flag.");

    a_under_reload: assert property (under_any && !feed_ok |=> s.cnt == $past(eff_load)) // see (R5)
        else $error("Underflow did not autoload the counter.");

    a_count_down: assert property (tap_tick && s.cnt != 8'h00 && !feed_ok && !feed_bad
        |=> s.cnt == $past(s.cnt) - 8'h01) // see (R4)
        else $error("Counter did not decrement by one on a tap tick.");

    a_pre_clear: assert property (under_any || feed_ok |=> s.pre == 13'h0000 && s.div == 4'h0) // see (R7)
        else $error("Prescaler not cleared on autoload.");

    a_stop_holds: assert property (!eff_run && !feed_ok && !feed_bad
        |=> $stable(s.cnt) && $stable(s.pre) && !s.under) // see (R24)
        else $error("Stopped timer changed or underflowed.");

    a_shadow_feed: assert property (!feed_ok |=> $stable(s.sh_mode) && $stable(s.sh_tap)) // see (R12)
        else $error("Shadow changed without a feed.");

    a_ctl_gated: assert property (!feed_ok |=> $stable(s.lowvolt_reset_enable) && $stable(s.oscfail_reset_enable)
        && $stable(s.mode) && $stable(s.tap)) // see (R15)
        else $error("Control bits changed without a feed.");

    a_bad_key: assert property (feed_bad |=> s.under) // see (R20)
        else $error("Wrong second key did not underflow.");

    a_wd_reset: assert property (under_any && !feed_ok && eff_mode |=> sys_reset_out [*8]) // see (R21)
        else $error("Watchdog underflow did not hold system reset.");

    a_timer_quiet: assert property (under_any && !eff_mode && !det_active && s.hold == 5'h00
        |=> !sys_reset_out) // see (R22)
        else $error("Timer underflow reset the system.");

    a_hold_after: assert property (det_active ##1 !det_active |-> sys_reset_out [*8]) // see (R18)
        else $error("Internal reset released too early.");

    a_ale_gated: assert property (sys_reset_out |-> !ale_enable) // see (R19)
        else $error("Address-latch strobe enabled during internal reset.");

    c_wd_under: cover property (under_any && eff_mode && !feed_bad);
    c_tm_under: cover property (under_any && !eff_mode);
    c_feed_good: cover property (feed_ok && s.pend_valid);
    c_feed_bad: cover property (feed_bad);

endmodule

/* dv/wdt_tb.sv */
`timescale 1ns/1ps
// Self-checking testbench for the watchdog timer with feed shadow.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module watchdog_timer_with_feed_shadow_tb;
import wdt_pkg::*;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic [7:0] awaddr = 8'h00;
logic [7:0] araddr = 8'h00;
logic [31:0] wdata = 32'h0000_0000;
logic awvalid = 1'b0;
logic wvalid = 1'b0;
logic bready = 1'b0;
logic arvalid = 1'b0;
logic rready = 1'b0;
logic lvd = 1'b0;
logic ofd = 1'b0;
logic awready, wready, bvalid, arready, rvalid, sys_reset_out, ale_enable, wd_underflow;
logic [1:0] bresp, rresp, r;
logic [31:0] rdata, d, rv;
int err_count = 0;
int comparisons = 0;
int seed = 76;
int n;
logic sr_seen;
// Behavioural model of the control value, the pending write, the autoload and the key state.
int m_ctl = 32'h0000_00fd;
int m_load = 0;
int m_pend = -1;
int m_arm = 0;

// Expected cycles from a feed to the underflow: 12 x 64 x 2^tap x (load + 1).
function automatic int exp_to();
    return (DIV_OSC * 64 << ((m_ctl >> BIT_TAP) & 7)) * (m_load + 1);
endfunction

// The oscillator and the bus share one 200 MHz clock.
always #2.5 aclk = ~aclk;

wdt_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_access_pin(1'b0), .poweron_detect(1'b0), .lowvolt_detect(lvd),
    .oscfail_detect(ofd), .sys_reset_out(sys_reset_out), .ale_enable(ale_enable),
    .wd_underflow(wd_underflow));

// Prints the counts and the verdict, then ends the run.
task conclude;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

// Holds the external reset for 20 cycles.
task do_reset;
    @(posedge aclk) aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    m_ctl = 32'h0000_00fd;
    m_load = 0;
    m_pend = -1;
    m_arm = 0;
endtask

// One AXI write; address and data are released as each is taken.
task wr(input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
        @(posedge aclk);
        k++;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 200);
    r = bresp;
    bready <= 1'b0;
    // Model: control writes wait for a good key pair; any other write disarms.
    if (r == RESP_OKAY)
    begin
        if (a == OFS_FEED2 && m_arm != 0 && v == FEED_KEY2 && m_pend >= 0)
        begin
            m_ctl = (m_pend & 32'h0000_00fd) | (m_ctl & 32'h0000_0002);
            m_pend = -1;
        end
        if (a == OFS_CONTROL) m_pend = v;
        if (a == OFS_AUTOLOAD) m_load = v;
        if (a == OFS_STATUS && v[0]) m_ctl = m_ctl & 32'h0000_00fd;
    end
    m_arm = (r == RESP_OKAY && a == OFS_FEED1 && v == FEED_KEY1);
    if (k >= 200) err_count++;
endtask

// One AXI read; the answer is taken at the edge where rvalid is seen.
task rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
        @(posedge aclk);
        k++;
        if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k >= 200) err_count++;
endtask

// Reads a register and compares it with the model value.
task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
    `CHK(r, RESP_OKAY)
endtask

// The two-key feed sequence.
task feed;
    wr(OFS_FEED1, FEED_KEY1);
    wr(OFS_FEED2, FEED_KEY2);
endtask

// Counts cycles until the underflow pulse, noting any system reset meanwhile.
task wait_uf(input int max);
    n = 0;
    sr_seen = 1'b0;
    while (wd_underflow !== 1'b1 && n < max)
    begin
        @(posedge aclk);
        n++;
        if (sys_reset_out) sr_seen = 1'b1;
    end
    // Every underflow sets the timeout flag in the model.
    if (wd_underflow === 1'b1) m_ctl = m_ctl | 32'h0000_0002;
endtask

// Counts how many cycles the internal reset stays high.
task reset_len;
    n = 0;
    while (sys_reset_out && n < 100)
    begin
        @(posedge aclk);
        n++;
    end
endtask

// Main sequence.
initial
begin
    do_reset;
    rc(OFS_CONTROL, m_ctl);
    rc(OFS_AUTOLOAD, m_load);
    rc(OFS_STATUS, 32'h0000_0f00);
    rd(8'he0);
    `CHK(r, RESP_SLVERR)
    wr(8'he0, 8'h11);
    `CHK(r, RESP_SLVERR)
    rv = $random(seed);
    wr(OFS_AUTOLOAD, rv[7:0]);
    rc(OFS_AUTOLOAD, m_load);
    wr(OFS_CONTROL, 8'h1c);
    rc(OFS_CONTROL, m_ctl);
    wr(OFS_AUTOLOAD, 8'h01);
    feed;
    wait_uf(4000);
    `CHK(n >= exp_to() - 6 && n <= exp_to() + 6, 1'b1)
    `CHK(sr_seen, 1'b0)
    rc(OFS_CONTROL, m_ctl);
    wr(OFS_STATUS, 8'h01);
    rc(OFS_CONTROL, m_ctl);
    rv = $random(seed);
    if (rv[7:0] == FEED_KEY2) rv = 32'h0000_0000;
    wr(OFS_FEED1, FEED_KEY1);
    wr(OFS_FEED2, rv[7:0]);
    wait_uf(10);
    `CHK(wd_underflow, 1'b1)
    rc(OFS_CONTROL, m_ctl);
    wr(OFS_CONTROL, 8'h18);
    feed;
    rd(OFS_STATUS);
    rv = d;
    wait_uf(3000);
    `CHK(wd_underflow, 1'b0)
    rc(OFS_STATUS, rv);
    @(posedge aclk) lvd <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(sys_reset_out, 1'b1)
    `CHK(ale_enable, 1'b0)
    lvd <= 1'b0;
    reset_len;
    `CHK(n >= 24 && n <= 30, 1'b1)
    wr(OFS_CONTROL, 8'h08);
    feed;
    rc(OFS_CONTROL, m_ctl);
    @(posedge aclk) lvd <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(sys_reset_out, 1'b0)
    lvd <= 1'b0;
    ofd <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(sys_reset_out, 1'b1)
    ofd <= 1'b0;
    repeat (40) @(posedge aclk);
    wr(OFS_AUTOLOAD, 8'h00);
    wr(OFS_CONTROL, 8'h1d);
    feed;
    wait_uf(1000);
    `CHK(n >= exp_to() - 6 && n <= exp_to() + 6, 1'b1)
    repeat (2) @(posedge aclk);
    `CHK(ale_enable, 1'b0)
    reset_len;
    `CHK(n >= 21 && n <= 24, 1'b1)
    rc(OFS_CONTROL, m_ctl);
    do_reset;
    rc(OFS_CONTROL, m_ctl);
    rc(OFS_AUTOLOAD, m_load);
    conclude;
end

// Cuts a hang short well beyond the expected run length.
initial
begin
    #500000;
    err_count++;
    conclude;
end
endmodule
